// ==== design/acc_clear_load_ops.sv ====
// decode and execute of the accumulator clear/load instructions and the flag
// side effect of the compatibility conditional return.
// assumes both instruction words and the resolved operand arrive in one cycle.
//
// Summary of operation
// - load-high-with-rounding puts operand in high half, 0x8000 in low half, one cycle.
// - after load-high-with-rounding, negative flag copies bit 31 of the accumulator.
// - after load-high-with-rounding, zero flag set only when accumulator is zero.
// - clear-overflow-count zeroes the six-bit counter, other status bits untouched.
// - zero-all clears accumulator, product register and overflow counter together.
// - zero-all leaves negative flag set and zero flag cleared.
// - these instructions are never repeated; repeat count is reset, one execution.
// - conditional return clears overflow flag whenever its condition tests it.
`timescale 1ns/1ps
`include "aclo_defines.svh"

module acc_clear_load_ops (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        instr_valid,
  input  wire logic [15:0] instr_word0,
  input  wire logic [15:0] instr_word1,
  input  wire logic [15:0] operand_data,
  output logic      [7:0]  operand_locator,
  input  wire logic        bio_in,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  output logic      [31:0] acc_out,
  output logic      [31:0] prod_out,
  output logic      [15:0] status_out,
  output logic      [15:0] repeat_count,
  output logic             instr_done,
  output logic             ret_pop,
  output logic             instr_unknown
);

  // --------------------------------------------------------------------------
  // state and decode
  // --------------------------------------------------------------------------
  aclo_pkg::aclo_state_t st;
  aclo_pkg::aclo_state_t next_st;
  aclo_pkg::aclo_kind_t  kind;
  logic                  exec;
  logic [31:0]           load_hi_result;
  logic                  load_hi_neg;
  logic                  load_hi_zero;
  logic                  cond_true;
  logic                  tests_v;
  logic [15:0]           rd_mux;

  // locator goes straight out so the addressing logic can answer this cycle
  assign operand_locator = instr_word1[7:0];

  // opcode match; the two-word form needs a zero upper byte in word 1
  always_comb begin
    kind = aclo_pkg::ACLO_KIND_NONE;
    if (instr_word0 == `ACLO_OP_LOAD_HI_RND && instr_word1[15:8] == `ACLO_LOC_HI_ZERO) begin
      kind = aclo_pkg::ACLO_KIND_LOAD_HI_RND;
    end else if (instr_word0 == `ACLO_OP_CLR_OVF_CNT) begin
      kind = aclo_pkg::ACLO_KIND_CLR_OVF_CNT;
    end else if (instr_word0 == `ACLO_OP_ZERO_ALL) begin
      kind = aclo_pkg::ACLO_KIND_ZERO_ALL;
    end else if (instr_word0[15:4] == `ACLO_OP_RETC_HI) begin
      kind = aclo_pkg::ACLO_KIND_RETC;
    end
  end

  // decoding is gated by the software enable bit
  assign exec = instr_valid & st.enable & (kind != aclo_pkg::ACLO_KIND_NONE);

  // rounding load result: operand on top, bias below
  // the bias is nonzero, so the zero flag can never rise on this load
  assign load_hi_result = {operand_data, `ACLO_ROUND_CONST};

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  aclo_flag_gen u_flag_gen (
    .result (load_hi_result),
    .neg    (load_hi_neg),
    .zero   (load_hi_zero)
  );

  aclo_cond_eval u_cond_eval (
    .cond      (instr_word0[3:0]),
    .flag_z    (st.status[`ACLO_ST_ZERO]),
    .flag_n    (st.status[`ACLO_ST_NEG]),
    .flag_c    (st.status[`ACLO_ST_CARRY]),
    .flag_v    (st.status[`ACLO_ST_OVF]),
    .flag_tc   (st.status[`ACLO_ST_TEST]),
    .bio       (bio_in),
    .cond_true (cond_true),
    .tests_v   (tests_v)
  );

  // --------------------------------------------------------------------------
  // register read mux
  // --------------------------------------------------------------------------
  // unmapped offsets read as zero
  always_comb begin
    unique case (reg_addr)
      `ACLO_REG_ACC_LO:    rd_mux = st.acc[15:0];
      `ACLO_REG_ACC_HI:    rd_mux = st.acc[31:16];
      `ACLO_REG_PROD_LO:   rd_mux = st.prod[15:0];
      `ACLO_REG_PROD_HI:   rd_mux = st.prod[31:16];
      `ACLO_REG_STATUS:    rd_mux = st.status;
      `ACLO_REG_REPEAT_CNT: rd_mux = st.repeat_cnt;
      `ACLO_REG_CTRL:      rd_mux = {15'h0000, st.enable};
      default:             rd_mux = 16'h0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  // software writes first, execution after: an instruction in the same cycle
  // overrides the fields it touches, so hardware effects are never lost
  always_comb begin
    next_st         = st;
    next_st.done    = 1'b0;
    next_st.ret_pop = 1'b0;
    next_st.unknown = 1'b0;
    next_st.rdata   = 16'h0000;
    if (reg_wr) begin
      unique case (reg_addr)
        `ACLO_REG_ACC_LO:    next_st.acc[15:0]  = reg_wdata;
        `ACLO_REG_ACC_HI:    next_st.acc[31:16] = reg_wdata;
        `ACLO_REG_PROD_LO:   next_st.prod[15:0] = reg_wdata;
        `ACLO_REG_PROD_HI:   next_st.prod[31:16] = reg_wdata;
        `ACLO_REG_STATUS:    next_st.status = reg_wdata & `ACLO_ST_USED_MASK;
        `ACLO_REG_REPEAT_CNT: next_st.repeat_cnt = reg_wdata;
        `ACLO_REG_CTRL:      next_st.enable = reg_wdata[`ACLO_CTRL_EN_BIT];
        default:             ;
      endcase
    end
    if (reg_rd) begin
      next_st.rdata = rd_mux;
    end
    if (instr_valid && st.enable && kind == aclo_pkg::ACLO_KIND_NONE) begin
      next_st.unknown = 1'b1;
    end
    if (exec) begin
      // none of these repeat: pending repeat count is dropped
      next_st.repeat_cnt = 16'h0000;
      next_st.done       = 1'b1;
      unique case (kind)
        // high half from the operand, low half the fixed rounding bias
        aclo_pkg::ACLO_KIND_LOAD_HI_RND: begin
          next_st.acc                   = load_hi_result;
          next_st.status[`ACLO_ST_NEG]  = load_hi_neg;
          next_st.status[`ACLO_ST_ZERO] = load_hi_zero;
        end
        // counter field only; flags and the other bits keep their value
        aclo_pkg::ACLO_KIND_CLR_OVF_CNT: begin
          next_st.status[`ACLO_ST_OVF_CNT_MSB:`ACLO_ST_OVF_CNT_LSB] = 6'h00;
        end
        // accumulator, product and counter together in one instruction
        aclo_pkg::ACLO_KIND_ZERO_ALL: begin
          next_st.acc  = 32'h0000_0000;
          next_st.prod = 32'h0000_0000;
          next_st.status[`ACLO_ST_OVF_CNT_MSB:`ACLO_ST_OVF_CNT_LSB] = 6'h00;
          // flags as specified for this op, not derived from the zero result
          next_st.status[`ACLO_ST_NEG]  = 1'b1;
          next_st.status[`ACLO_ST_ZERO] = 1'b0;
        end
        aclo_pkg::ACLO_KIND_RETC: begin
          next_st.ret_pop = cond_true;
          if (tests_v) begin
            next_st.status[`ACLO_ST_OVF] = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st           <= '0;
      st.status    <= `ACLO_RST_STATUS;
      st.enable    <= `ACLO_RST_CTRL;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from flops
  assign reg_rdata     = st.rdata;
  assign acc_out       = st.acc;
  assign prod_out      = st.prod;
  assign status_out    = st.status;
  assign repeat_count  = st.repeat_cnt;
  assign instr_done    = st.done;
  assign ret_pop       = st.ret_pop;
  assign instr_unknown = st.unknown;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  // one named step per executed instruction kind
  sequence seq_load_hi;
    exec && kind == aclo_pkg::ACLO_KIND_LOAD_HI_RND;
  endsequence

  sequence seq_zero_all;
    exec && kind == aclo_pkg::ACLO_KIND_ZERO_ALL;
  endsequence

  // a status write in the same cycle may legally touch the other bits
  sequence seq_clr_ovf_cnt;
    exec && kind == aclo_pkg::ACLO_KIND_CLR_OVF_CNT && !reg_wr;
  endsequence

  sequence seq_retc_v;
    exec && kind == aclo_pkg::ACLO_KIND_RETC && tests_v;
  endsequence

  // a return whose code ignores v, with no software write beside it
  sequence seq_retc_keep;
    exec && kind == aclo_pkg::ACLO_KIND_RETC && !tests_v && !reg_wr;
  endsequence

  // a word that must leave every register alone
  sequence seq_refused;
    instr_valid && (!st.enable || kind == aclo_pkg::ACLO_KIND_NONE) && !reg_wr;
  endsequence

  AST_LOAD_HI_ACC: assert property (seq_load_hi |=>
      acc_out == {$past(operand_data), `ACLO_ROUND_CONST} && instr_done)
    else $error("rounding load gave wrong accumulator");

  AST_LOAD_HI_NEG: assert property (seq_load_hi |=> status_out[`ACLO_ST_NEG] == $past(operand_data[15]))
    else $error("negative flag does not follow accumulator bit 31");

  AST_LOAD_HI_ZERO: assert property (seq_load_hi |=>
      status_out[`ACLO_ST_ZERO] == (acc_out == 32'h0000_0000))
    else $error("zero flag wrong after rounding load");

  AST_OVF_CNT_CLEAR: assert property (seq_clr_ovf_cnt |=>
      status_out[15:10] == 6'h00 && status_out[9:0] == $past(status_out[9:0]))
    else $error("overflow count clear disturbed other status bits");

  AST_ZERO_ALL_CLEAR: assert property (seq_zero_all |=>
      acc_out == 32'h0000_0000 && prod_out == 32'h0000_0000 && status_out[15:10] == 6'h00)
    else $error("zero-all left a register nonzero");

  AST_ZERO_ALL_FLAGS: assert property (seq_zero_all |=>
      status_out[`ACLO_ST_NEG] && !status_out[`ACLO_ST_ZERO])
    else $error("zero-all flags wrong");

  AST_REPEAT_DROP: assert property (exec |=> repeat_count == 16'h0000 ##1 (!instr_done || $past(exec)))
    else $error("repeat count survived a non-repeatable op");

  AST_RET_V_CLR: assert property (seq_retc_v |=> !status_out[`ACLO_ST_OVF])
    else $error("overflow flag not cleared by return test");

  AST_RET_POP: assert property (exec && kind == aclo_pkg::ACLO_KIND_RETC |=> ret_pop == $past(cond_true))
    else $error("return pop does not match condition");

  AST_LOCATOR: assert property (instr_valid |-> operand_locator == instr_word1[7:0])
    else $error("locator not taken from low byte");

  // status readback lands exactly one cycle after the strobe
  AST_READ_LAT: assert property (reg_rd && reg_addr == `ACLO_REG_STATUS |=> reg_rdata == $past(status_out))
    else $error("read data not presented one cycle after strobe");

  // read data stands for one cycle only, zero otherwise
  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data outlived its cycle");

  // the v clear is the only status change a return may make
  AST_RET_KEEP: assert property (seq_retc_keep |=> status_out == $past(status_out))
    else $error("return disturbed status bits it does not own");

  // refused or unknown words change nothing and raise no completion
  AST_REFUSED_IDLE: assert property (seq_refused |=> !instr_done && !ret_pop && acc_out == $past(acc_out)
      && prod_out == $past(prod_out) && status_out == $past(status_out))
    else $error("refused instruction changed state");

  // the unknown flag is raised only while the decoder is enabled
  AST_UNKNOWN_GATE: assert property (instr_valid && !st.enable |=> !instr_unknown)
    else $error("disabled decoder flagged an unknown word");

  // a word is either executed or refused, never both
  AST_PULSE_EXCL: assert property (!(instr_done && instr_unknown))
    else $error("done and unknown raised together");

  // bits between the flags and the counter always read zero
  AST_STATUS_GAP: assert property (status_out[9:5] == 5'h00)
    else $error("unused status bits went nonzero");

  // the enable bit follows a control write on the next edge
  AST_CTRL_WRITE: assert property (reg_wr && reg_addr == `ACLO_REG_CTRL |=>
      st.enable == $past(reg_wdata[`ACLO_CTRL_EN_BIT]))
    else $error("enable bit did not follow control write");

endmodule // acc_clear_load_ops

// ==== design/aclo_cond_eval.sv ====
// condition code evaluation for the compatibility conditional return.
// purely combinational; flags arrive from the caller's status register.
`timescale 1ns/1ps
`include "aclo_defines.svh"

module aclo_cond_eval (
  input  wire logic [3:0] cond,
  input  wire logic       flag_z,
  input  wire logic       flag_n,
  input  wire logic       flag_c,
  input  wire logic       flag_v,
  input  wire logic       flag_tc,
  input  wire logic       bio,
  output logic            cond_true,
  output logic            tests_v
);

  // sixteen codes, all legal, so no default
  always_comb begin
    unique case (cond)
      4'h0: cond_true = ~flag_z;
      4'h1: cond_true = flag_z;
      4'h2: cond_true = ~flag_z & ~flag_n;
      4'h3: cond_true = ~flag_n;
      4'h4: cond_true = flag_n;
      4'h5: cond_true = flag_z | flag_n;
      4'h6: cond_true = flag_c & ~flag_z;
      4'h7: cond_true = flag_c;
      4'h8: cond_true = ~flag_c;
      4'h9: cond_true = ~flag_c | flag_z;
      4'ha: cond_true = ~flag_v;
      4'hb: cond_true = flag_v;
      4'hc: cond_true = ~flag_tc;
      4'hd: cond_true = flag_tc;
      4'he: cond_true = ~bio;
      4'hf: cond_true = 1'b1;
    endcase
  end

  // only the two overflow codes look at v
  assign tests_v = (cond == `ACLO_COND_NOV) || (cond == `ACLO_COND_OV);

endmodule // aclo_cond_eval

// ==== design/aclo_defines.svh ====
// constants for the accumulator clear/load decoder: opcodes, register offsets,
// status field positions and reset values. assumes inclusion by bare name.
`ifndef ACLO_DEFINES_SVH
`define ACLO_DEFINES_SVH

// ----------------------------------------------------------------------------
// opcodes (first instruction word)
// ----------------------------------------------------------------------------
`define ACLO_OP_LOAD_HI_RND 16'h5613
`define ACLO_OP_CLR_OVF_CNT 16'h565c
`define ACLO_OP_ZERO_ALL    16'h5633
`define ACLO_OP_RETC_HI     12'h56f
`define ACLO_LOC_HI_ZERO    8'h00
`define ACLO_ROUND_CONST    16'h8000

// ----------------------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------------------
`define ACLO_REG_ACC_LO     4'h0
`define ACLO_REG_ACC_HI     4'h1
`define ACLO_REG_PROD_LO    4'h2
`define ACLO_REG_PROD_HI    4'h3
`define ACLO_REG_STATUS     4'h4
`define ACLO_REG_REPEAT_CNT 4'h5
`define ACLO_REG_CTRL       4'h6

// ----------------------------------------------------------------------------
// status_reg_zero field positions
// ----------------------------------------------------------------------------
`define ACLO_ST_CARRY       0
`define ACLO_ST_ZERO        1
`define ACLO_ST_NEG         2
`define ACLO_ST_OVF         3
`define ACLO_ST_TEST        4
`define ACLO_ST_OVF_CNT_LSB 10
`define ACLO_ST_OVF_CNT_MSB 15
`define ACLO_ST_USED_MASK   16'hfc1f

// ----------------------------------------------------------------------------
// condition codes that look at the overflow flag
// ----------------------------------------------------------------------------
`define ACLO_COND_NOV       4'ha
`define ACLO_COND_OV        4'hb

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define ACLO_RST_STATUS     16'h0000
`define ACLO_RST_CTRL       1'b1
`define ACLO_CTRL_EN_BIT    0

`endif

// ==== design/aclo_flag_gen.sv ====
// negative and zero detection on a 32-bit accumulator result.
// purely combinational; the caller registers the flags.
`timescale 1ns/1ps

module aclo_flag_gen (
  input  wire logic [31:0] result,
  output logic             neg,
  output logic             zero
);

  // sign bit and all-zero test
  assign neg  = result[31];
  assign zero = (result == 32'h0000_0000);

endmodule // aclo_flag_gen

// ==== design/aclo_pkg.sv ====
// types shared by the accumulator clear/load decoder.
// assumes nothing beyond a systemverilog compiler.
package aclo_pkg;

  // --------------------------------------------------------------------------
  // decoded instruction kind
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ACLO_KIND_NONE,
    ACLO_KIND_LOAD_HI_RND,
    ACLO_KIND_CLR_OVF_CNT,
    ACLO_KIND_ZERO_ALL,
    ACLO_KIND_RETC
  } aclo_kind_t;

  // --------------------------------------------------------------------------
  // whole state of the top module
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] acc;
    logic [31:0] prod;
    logic [15:0] status;
    logic [15:0] repeat_cnt;
    logic        enable;
    logic [15:0] rdata;
    logic        done;
    logic        ret_pop;
    logic        unknown;
  } aclo_state_t;

endpackage

// ==== verif/acc_clear_load_ops_tb_top.sv ====
// self-checking bench for the accumulator clear/load decoder.
// assumes the design files and aclo_defines.svh are compiled alongside.
`timescale 1ns/1ps
`include "aclo_defines.svh"

module acc_clear_load_ops_tb_top;
  logic        ref_clk;
  logic        srst;
  logic        instr_valid;
  logic [15:0] instr_word0;
  logic [15:0] instr_word1;
  logic [15:0] operand_data;
  logic [7:0]  operand_locator;
  logic        bio_in;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [31:0] acc_out;
  logic [31:0] prod_out;
  logic [15:0] status_out;
  logic [15:0] repeat_count;
  logic        instr_done;
  logic        ret_pop;
  logic        instr_unknown;
  int          n_mismatch;
  int          checks_done;
  logic [31:0] seed;
  logic [15:0] exp_st;
  logic [15:0] d;
  logic [15:0] rv;
  logic [31:0] exp_acc;

  acc_clear_load_ops u_acc_clear_load_ops (
    .ref_clk(ref_clk), .srst(srst), .instr_valid(instr_valid), .instr_word0(instr_word0),
    .instr_word1(instr_word1), .operand_data(operand_data), .operand_locator(operand_locator),
    .bio_in(bio_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .acc_out(acc_out), .prod_out(prod_out), .status_out(status_out),
    .repeat_count(repeat_count), .instr_done(instr_done), .ret_pop(ret_pop),
    .instr_unknown(instr_unknown)
  );

  // ----------------------------------------------------------------------------
  // clock, random source, expectation helpers
  // ----------------------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // shift-register source keeps every run identical
  function automatic logic [15:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[15:0] ^ seed[31:16];
  endfunction

  // condition table of the compatibility return
  function automatic logic cond_ok(input logic [3:0] c, input logic [15:0] s, input logic b);
    logic z, n, cy, v, tc;
    z  = s[`ACLO_ST_ZERO];
    n  = s[`ACLO_ST_NEG];
    cy = s[`ACLO_ST_CARRY];
    v  = s[`ACLO_ST_OVF];
    tc = s[`ACLO_ST_TEST];
    case (c)
      4'h0: return !z;
      4'h1: return z;
      4'h2: return !z && !n;
      4'h3: return !n;
      4'h4: return n;
      4'h5: return z || n;
      4'h6: return cy && !z;
      4'h7: return cy;
      4'h8: return !cy;
      4'h9: return !cy || z;
      4'ha: return !v;
      4'hb: return v;
      4'hc: return !tc;
      4'hd: return tc;
      4'he: return !b;
      default: return 1'b1;
    endcase
  endfunction

  // ----------------------------------------------------------------------------
  // drivers and comparison
  // ----------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // one instruction; the locator is combinational, so it is looked at before the edge
  task automatic exe(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] od);
    @(posedge ref_clk);
    instr_valid  <= 1'b1;
    instr_word0  <= w0;
    instr_word1  <= w1;
    operand_data <= od;
    #1;
    check("operand_locator", {24'h0, operand_locator}, {24'h0, w1[7:0]});
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // bounded run: a hang counts against the design
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    $display("ERROR watchdog expected finish seen hang");
    conclude();
  end

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    {instr_valid, reg_wr, reg_rd, bio_in} = 4'h0;
    {instr_word0, instr_word1, operand_data, reg_wdata} = 64'h0;
    reg_addr = 4'h0;
    n_mismatch = 0;
    checks_done = 0;
    seed = 32'hd85d;
    srst = 1'b1;
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    #1;
    check("status reset", {16'h0, status_out}, {16'h0, `ACLO_RST_STATUS});
    check("acc reset", acc_out, 32'h0);
    rd(`ACLO_REG_CTRL, rv);
    check("ctrl reset", {16'h0, rv}, 32'h1);
    @(posedge ref_clk);
    #1;
    check("rdata one cycle", {16'h0, reg_rdata}, 32'h0);
    rd(4'hf, rv);
    check("unmapped read", {16'h0, rv}, 32'h0);
    exp_st = 16'h0;
    $display("test reset done");

    // load high with rounding: corner operands first, then random, repeat count armed
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 16'h0000 : (i == 1) ? 16'h8000 : (i == 2) ? 16'h7fff : rnd();
      wr(`ACLO_REG_REPEAT_CNT, rnd() | 16'h1);
      rv = rnd();
      exe(`ACLO_OP_LOAD_HI_RND, {`ACLO_LOC_HI_ZERO, rv[7:0]}, d);
      exp_acc = {d, `ACLO_ROUND_CONST};
      exp_st[`ACLO_ST_NEG]  = exp_acc[31];
      exp_st[`ACLO_ST_ZERO] = (exp_acc == 32'h0);
      check("load_hi acc", acc_out, exp_acc);
      check("load_hi done", {31'h0, instr_done}, 32'h1);
      check("load_hi status", {16'h0, status_out}, {16'h0, exp_st});
      check("load_hi repeat", {16'h0, repeat_count}, 32'h0);
      rd(`ACLO_REG_ACC_LO, rv);
      check("load_hi acc_lo read", {16'h0, rv}, {16'h0, `ACLO_ROUND_CONST});
      rd(`ACLO_REG_ACC_HI, rv);
      check("load_hi acc_hi read", {16'h0, rv}, {16'h0, d});
    end
    $display("test load_high done");

    // clear overflow count: other status bits survive
    for (int i = 0; i < 4; i++) begin
      exp_st = rnd() & `ACLO_ST_USED_MASK;
      wr(`ACLO_REG_STATUS, exp_st);
      wr(`ACLO_REG_REPEAT_CNT, 16'hffff);
      exe(`ACLO_OP_CLR_OVF_CNT, 16'h0, rnd());
      exp_st[15:10] = 6'h0;
      check("ovf_cnt clear", {16'h0, status_out}, {16'h0, exp_st});
      check("ovf_cnt repeat", {16'h0, repeat_count}, 32'h0);
    end
    rd(`ACLO_REG_STATUS, rv);
    check("status read", {16'h0, rv}, {16'h0, exp_st});
    $display("test clear_ovf_cnt done");

    // zero all: accumulator and product high half from random contents, counter from all ones
    for (int i = 0; i < 4; i++) begin
      wr(`ACLO_REG_ACC_LO, rnd());
      wr(`ACLO_REG_ACC_HI, rnd() | 16'h1);
      wr(`ACLO_REG_PROD_HI, rnd() | 16'h1);
      exp_st = (rnd() | 16'hfc02) & `ACLO_ST_USED_MASK;
      wr(`ACLO_REG_STATUS, exp_st);
      wr(`ACLO_REG_REPEAT_CNT, 16'h0005);
      exe(`ACLO_OP_ZERO_ALL, 16'h0, rnd());
      exp_st[15:10] = 6'h0;
      exp_st[`ACLO_ST_NEG]  = 1'b1;
      exp_st[`ACLO_ST_ZERO] = 1'b0;
      check("zero_all acc", acc_out, 32'h0);
      check("zero_all prod", prod_out, 32'h0);
      check("zero_all status", {16'h0, status_out}, {16'h0, exp_st});
      check("zero_all repeat", {16'h0, repeat_count}, 32'h0);
    end
    $display("test zero_all done");

    // conditional return over every condition code twice, overflow forced set beforehand on the second pass
    for (int c = 0; c < 32; c++) begin
      exp_st = (rnd() | (c[4] ? 16'h0008 : 16'h0)) & `ACLO_ST_USED_MASK;
      wr(`ACLO_REG_STATUS, exp_st);
      wr(`ACLO_REG_REPEAT_CNT, 16'h0003);
      rv = rnd();
      bio_in <= rv[0];
      @(posedge ref_clk);
      exe({`ACLO_OP_RETC_HI, c[3:0]}, 16'h0, 16'h0);
      check("ret pop", {31'h0, ret_pop}, {31'h0, cond_ok(c[3:0], exp_st, bio_in)});
      if (c[3:0] == `ACLO_COND_NOV || c[3:0] == `ACLO_COND_OV)
        exp_st[`ACLO_ST_OVF] = 1'b0;
      check("ret status", {16'h0, status_out}, {16'h0, exp_st});
      check("ret repeat", {16'h0, repeat_count}, 32'h0);
    end
    $display("test cond_return done");

    // refusals: foreign opcode, bad second word, disabled decoder
    exp_acc = acc_out;
    exe(16'h1234, 16'h0, 16'h5555);
    check("unknown pulse", {31'h0, instr_unknown}, 32'h1);
    exe(`ACLO_OP_LOAD_HI_RND, 16'h0100, 16'h5555);
    check("bad word1", {31'h0, instr_unknown}, 32'h1);
    check("bad word1 acc", acc_out, exp_acc);
    wr(`ACLO_REG_CTRL, 16'h0);
    exe(`ACLO_OP_LOAD_HI_RND, 16'h0000, 16'h5555);
    check("disabled done", {31'h0, instr_done}, 32'h0);
    check("disabled unknown", {31'h0, instr_unknown}, 32'h0);
    check("disabled acc", acc_out, exp_acc);
    wr(`ACLO_REG_CTRL, 16'h1);
    $display("test refusals done");
    conclude();
  end
endmodule // acc_clear_load_ops_tb_top
